// [hdl/tlg_divider.sv]
// Decade divider: turns a 1 MHz tick into two interval pulse trains.
// Assumes tick_i is a one-cycle enable on clock_i.
`timescale 1ns/1ps
`default_nettype none
module tlg_divider #(
  parameter int unsigned CW = 20
) (
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  // Control
  input  wire logic          tick_i,
  input  wire logic          clear_i,
  input  wire logic [CW-1:0] stage1_i,
  // Pulses
  output logic               stage1_o,
  output logic               stage2_o
);
  typedef struct packed {
    logic [CW-1:0] c1;
    logic [6:0]    c2;
    logic          p1;
    logic          p2;
  } tlg_div_s;

  // Second stage counts this many first stage pulses (half period)
  localparam logic [6:0] STAGE2_N = 7'(tlg_pkg::DECADE * tlg_pkg::DECADE / 2);
  tlg_div_s s_q, s_d;

  always_comb begin
    s_d    = s_q;
    s_d.p1 = 1'b0;
    s_d.p2 = 1'b0;
    if (clear_i) begin
      s_d.c1 = '0;
      s_d.c2 = '0;
    end else if (tick_i) begin
      if (s_q.c1 >= stage1_i - CW'(1)) begin
        s_d.c1 = '0;
        s_d.p1 = 1'b1;
        if (s_q.c2 >= STAGE2_N - 7'h01) begin
          s_d.c2 = '0;
          s_d.p2 = 1'b1;
        end else begin
          s_d.c2 = s_q.c2 + 7'h01;
        end
      end else begin
        s_d.c1 = s_q.c1 + CW'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stage1_o = s_q.p1;
  assign stage2_o = s_q.p2;
endmodule // tlg_divider
`default_nettype wire

// [hdl/tlg_top.sv]
// Transient level generator with APB register access.
// Assumes a 200 MHz clock and an external trigger from a pin.
//
// What this block does
// - Alternate load between two levels by one select output only.
// - Level select output is active low, sent to the level DACs.
// - All transient timing comes from an internal 1 MHz tick.
// - Reset configuration is 1000 Hz with 50 percent duty.
// - Three bit rate select picks 10 kHz down to 1 Hz.
// - Divider pulses last one clock cycle; stage intervals scale by ten per decade.
// - Toggle and pulse modes besides free running, chosen in the control register.
// - Enable low at reset and after off; square wave only while high.
// - Trigger comes from bus command or external trigger input.
// - Either trigger applies a preset level or advances toggle/pulse.
// - Pulse mode with bus source: each bus trigger toggles event lines.
// - Run indication toggles once when a triggered sequence starts.
// - Trigger while level pending toggles event lines once.
// - Level change lines toggle when a new immediate level is written.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tlg_top (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Trigger pin
  input  wire logic        external_trigger_input_i,
  // Level control and indications
  output logic             level_select_n_o,
  output logic             transient_enable_o,
  output logic             trigger_event_line_o,
  output logic             level_change_line_o,
  output logic             run_start_line_o,
  output logic [15:0]      immediate_level_o,
  output logic [15:0]      triggered_level_o
);
  localparam int unsigned CW = 24;
  localparam int unsigned S1 = tlg_pkg::STAGE1_BASE;
  localparam int unsigned DK = tlg_pkg::DECADE;

  typedef struct packed {
    logic [7:0]              tdiv;
    logic                    tick;
    logic [2:0]              rate;
    tlg_pkg::tlg_mode_e      mode;
    logic                    bus_src;
    logic                    en;
    logic                    high;
    logic                    sel_n;
    logic                    pend;
    logic                    trig_ev;
    logic                    lev_ch;
    logic                    run;
    logic [15:0]             imm;
    logic [15:0]             trg;
    logic [2:0]              xtr;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } tlg_s;

  tlg_s s_q, s_d;

  // Reset release synchroniser
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // First stage interval in ticks for a rate code
  function automatic logic [CW-1:0] stage1_len(input logic [2:0] r);
    logic [CW-1:0] v;
    v = CW'(tlg_pkg::STAGE1_BASE);
    unique case (r)
      tlg_pkg::RATE_10K: v = CW'(S1);
      tlg_pkg::RATE_1K:  v = CW'(S1 * DK);
      tlg_pkg::RATE_100: v = CW'(S1 * DK * DK);
      tlg_pkg::RATE_10:  v = CW'(S1 * DK * DK * DK);
      tlg_pkg::RATE_1:   v = CW'(S1 * DK * DK * DK * DK);
      default:           v = CW'(S1 * DK);
    endcase
    return v;
  endfunction

  logic st2;

  tlg_divider #(
    .CW (CW)
  ) u_div (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n),
    .tick_i   (s_q.tick),
    .clear_i  (~s_q.en),
    .stage1_i (stage1_len(s_q.rate)),
    .stage1_o (),
    .stage2_o (st2)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic apb_wr, apb_rd, trig_any, bus_trig, ext_edge;
  logic [11:0] addr;

  always_comb begin
    addr     = paddr_i;
    apb_wr   = psel_i && penable_i && pwrite_i;
    apb_rd   = psel_i && !penable_i && !pwrite_i;
    s_d      = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    bus_trig = 1'b0;

    // 1 MHz tick from the system clock
    s_d.tick = 1'b0;
    if (s_q.tdiv == 8'(tlg_pkg::TICK_DIV - 1)) begin
      s_d.tdiv = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.tdiv = s_q.tdiv + 8'h01;
    end

    // Pin synchroniser; third stage only for edge detection
    s_d.xtr = {s_q.xtr[1:0], external_trigger_input_i};
    ext_edge = s_q.xtr[1] && !s_q.xtr[2];

    // APB: answer one cycle after setup, ready in access phase
    if (psel_i && !penable_i) begin
      s_d.pready = 1'b1;
      unique case (addr)
        tlg_pkg::ADDR_CTRL, tlg_pkg::ADDR_CMD,
        tlg_pkg::ADDR_STATUS, tlg_pkg::ADDR_LEVEL: s_d.pslverr = 1'b0;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (apb_rd) begin
      s_d.prdata = 32'h0;
      unique case (addr)
        tlg_pkg::ADDR_CTRL: begin
          s_d.prdata[tlg_pkg::CTRL_RATE_LSB +: 3] = s_q.rate;
          s_d.prdata[tlg_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
          s_d.prdata[tlg_pkg::CTRL_SRC_BIT]       = s_q.bus_src;
        end
        tlg_pkg::ADDR_STATUS: begin
          s_d.prdata[tlg_pkg::ST_EN]    = s_q.en;
          s_d.prdata[tlg_pkg::ST_LEVEL] = s_q.high;
          s_d.prdata[tlg_pkg::ST_PEND]  = s_q.pend;
          s_d.prdata[tlg_pkg::ST_TRIG]  = s_q.trig_ev;
          s_d.prdata[tlg_pkg::ST_LEV]   = s_q.lev_ch;
          s_d.prdata[tlg_pkg::ST_RUN]   = s_q.run;
        end
        tlg_pkg::ADDR_LEVEL:
          s_d.prdata = {s_q.trg, s_q.imm};
        default: s_d.prdata = 32'h0;
      endcase
    end

    if (apb_wr && s_q.pready && !s_q.pslverr) begin
      unique case (addr)
        tlg_pkg::ADDR_CTRL: begin
          s_d.rate = pwdata_i[tlg_pkg::CTRL_RATE_LSB +: 3];
          unique case (pwdata_i[tlg_pkg::CTRL_MODE_LSB +: 2])
            2'h1:    s_d.mode = tlg_pkg::TLG_MODE_TOGGLE;
            2'h2:    s_d.mode = tlg_pkg::TLG_MODE_PULSE;
            default: s_d.mode = tlg_pkg::TLG_MODE_CONT;
          endcase
          s_d.bus_src = pwdata_i[tlg_pkg::CTRL_SRC_BIT];
        end
        tlg_pkg::ADDR_CMD: begin
          if (pwdata_i[tlg_pkg::CMD_ON]) begin
            s_d.en = 1'b1;
          end
          if (pwdata_i[tlg_pkg::CMD_OFF]) begin
            s_d.en   = 1'b0;
            s_d.high = 1'b0;
          end
          bus_trig = pwdata_i[tlg_pkg::CMD_TRIG];
        end
        tlg_pkg::ADDR_LEVEL: begin
          // Upper half: triggered level, applied by the next trigger while armed
          if (pwdata_i[31:16] != s_q.trg || !s_q.pend) begin
            s_d.trg = pwdata_i[31:16];
          end
          // changed immediate level toggles change line
          if (pwdata_i[15:0] != s_q.imm) begin
            s_d.imm    = pwdata_i[15:0];
            s_d.lev_ch = ~s_q.lev_ch;
          end
        end
        default: s_d.pslverr = 1'b0;
      endcase
      // run indication toggles once on arming
      if (addr == tlg_pkg::ADDR_CMD && pwdata_i[tlg_pkg::CMD_ARM]
          && !s_q.pend) begin
        s_d.pend = 1'b1;
        s_d.run  = ~s_q.run;
      end
    end

    trig_any = s_q.bus_src ? bus_trig : ext_edge;

    if (trig_any) begin
      if (s_q.pend) begin
        s_d.pend    = 1'b0;
        s_d.imm     = s_q.trg;
        s_d.trig_ev = ~s_q.trig_ev;
      end
      if (s_q.en && s_q.mode != tlg_pkg::TLG_MODE_CONT) begin
        if (!s_q.pend) begin
          s_d.trig_ev = ~s_q.trig_ev;
        end
        if (s_q.mode == tlg_pkg::TLG_MODE_TOGGLE) begin
          s_d.high = ~s_q.high;
        end else begin
          s_d.high = 1'b1;
        end
      end
    end

    // square wave on second stage pulses
    if (s_q.en && st2) begin
      if (s_q.mode == tlg_pkg::TLG_MODE_CONT) begin
        s_d.high = ~s_q.high;
      end else if (s_q.mode == tlg_pkg::TLG_MODE_PULSE) begin
        // Pulse returns low at the next second stage pulse
        s_d.high = 1'b0;
      end
    end
    if (!s_d.en) begin
      s_d.high = 1'b0;
    end
    // select kept in its own flop
    s_d.sel_n = ~s_d.high;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      // reset to 1 kHz, 50 percent
      s_q.rate <= tlg_pkg::RATE_RST;
      s_q.mode <= tlg_pkg::TLG_MODE_CONT;
      s_q.sel_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active low level select
  assign level_select_n_o     = s_q.sel_n;
  assign transient_enable_o   = s_q.en;
  assign trigger_event_line_o = s_q.trig_ev;
  assign level_change_line_o  = s_q.lev_ch;
  assign run_start_line_o     = s_q.run;
  assign immediate_level_o    = s_q.imm;
  assign triggered_level_o    = s_q.trg;
  assign prdata_o             = s_q.prdata;
  assign pready_o             = s_q.pready;
  assign pslverr_o            = s_q.pslverr;
endmodule // tlg_top
`default_nettype wire

// [include/tlg_pkg.sv]
// Constants for the transient level generator.
// Assumes a 200 MHz system clock; the 1 MHz tick is derived from it.
`default_nettype none
package tlg_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned TICK_HZ     = 1_000_000;
  localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
  // First stage interval at 10 kHz, in 1 MHz ticks
  localparam int unsigned STAGE1_BASE = 1;
  localparam int unsigned DECADE      = 10;
  // Rate select codes
  localparam logic [2:0] RATE_10K  = 3'h0;
  localparam logic [2:0] RATE_1K   = 3'h1;
  localparam logic [2:0] RATE_100  = 3'h2;
  localparam logic [2:0] RATE_10   = 3'h3;
  localparam logic [2:0] RATE_1    = 3'h4;
  localparam logic [2:0] RATE_RST  = RATE_1K;
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CMD    = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_LEVEL  = 12'h00C;
  // Control fields
  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_SRC_BIT  = 8;
  // Command bits (write one to act)
  localparam int unsigned CMD_ON    = 0;
  localparam int unsigned CMD_OFF   = 1;
  localparam int unsigned CMD_TRIG  = 2;
  localparam int unsigned CMD_ARM   = 3;
  // Status fields
  localparam int unsigned ST_EN     = 0;
  localparam int unsigned ST_LEVEL  = 1;
  localparam int unsigned ST_PEND   = 2;
  localparam int unsigned ST_TRIG   = 3;
  localparam int unsigned ST_LEV    = 4;
  localparam int unsigned ST_RUN    = 5;
  localparam int unsigned LEVEL_W   = 16;
  // Modes
  typedef enum logic [1:0] {
    TLG_MODE_CONT,
    TLG_MODE_TOGGLE,
    TLG_MODE_PULSE
  } tlg_mode_e;
endpackage
`default_nettype wire

// [tb/tb_top.sv]
// Bench for the transient level generator, driven over APB.
// Assumes zero wait state slave; 10 kHz rate keeps the run short.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("FAIL %0t got %0h want %0h", $time, a, b); end end
module tb_top;
  logic        clock_i, arst_n_i, psel_i, penable_i, pwrite_i, fire, ext;
  logic        sel_n, en, trg, lvc, run, err, t0, rdy;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata, rd, v, edges, gap, e0;
  logic [15:0] imm, tlv;
  int unsigned fails, checked;
  localparam int unsigned HALF_10K = 50 * tlg_pkg::TICK_DIV;
  tlg_top u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
    .external_trigger_input_i(ext), .level_select_n_o(sel_n),
    .transient_enable_o(en), .trigger_event_line_o(trg),
    .level_change_line_o(lvc), .run_start_line_o(run),
    .immediate_level_o(imm), .triggered_level_o(tlv));
  tlg_load_model u_far (.clock_i(clock_i), .level_select_n_i(sel_n),
    .fire_i(fire), .external_trigger_o(ext), .edges_o(edges), .gap_o(gap));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked != 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    rd = prdata;
    t0 = err;
    if (k >= 20) begin
      $display("FAIL %0t bus timeout", $time);
      fails++;
      results();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wait_sel(input int unsigned lim);
    int k;
    k = 0;
    e0 = edges;
    while (edges == e0 && k < lim) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= lim) begin
      $display("FAIL %0t select timeout", $time);
      fails++;
      results();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i, fire} = 5'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK(sel_n, 1'b1)
    apb(1'b0, tlg_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd[5:0], 6'h01)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({t0, rd}, {1'b1, 32'h0})
    for (int i = 0; i < 5; i++) begin
      v = 32'(i) | (32'(i % 3) << 4) | (32'(i % 2) << 8);
      apb(1'b1, tlg_pkg::ADDR_CTRL, v);
      apb(1'b0, tlg_pkg::ADDR_CTRL, 32'h0);
      `CHK(rd[8:0], v[8:0])
    end
    $display("test reset and config done");
    apb(1'b1, tlg_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h1);
    apb(1'b0, tlg_pkg::ADDR_STATUS, 32'h0);
    `CHK({en, rd[0]}, 2'h3)
    wait_sel(12000);
    wait_sel(12000);
    `CHK(gap, HALF_10K)
    wait_sel(12000);
    `CHK(gap, HALF_10K)
    `CHK(imm, 16'h0)
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h3);
    @(posedge clock_i);
    e0 = edges;
    repeat (12000) @(posedge clock_i);
    `CHK({en, sel_n, edges}, {1'b0, 1'b1, e0})
    $display("test free run done");
    apb(1'b1, tlg_pkg::ADDR_CTRL, 32'h120);
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h1);
    for (int i = 0; i < 3; i++) begin
      v[0] = trg;
      apb(1'b1, tlg_pkg::ADDR_CMD, 32'h4);
      `CHK(trg, ~v[0])
    end
    apb(1'b1, tlg_pkg::ADDR_CTRL, 32'h010);
    v[0] = trg;
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h4);
    `CHK(trg, v[0])
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    wait_sel(40);
    repeat (2) @(posedge clock_i);
    `CHK({trg, edges}, {~v[0], e0 + 32'h1})
    $display("test trigger modes done");
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h2);
    apb(1'b1, tlg_pkg::ADDR_CTRL, 32'h100);
    apb(1'b1, tlg_pkg::ADDR_LEVEL, 32'h0005_0000);
    `CHK(tlv, 16'h0005)
    v = {run, trg, lvc};
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h8);
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h8);
    `CHK(run, ~v[2])
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h4);
    `CHK({trg, imm}, {~v[1], 16'h0005})
    apb(1'b1, tlg_pkg::ADDR_LEVEL, 32'h0005_0001);
    `CHK(lvc, ~v[0])
    apb(1'b1, tlg_pkg::ADDR_CMD, 32'h4);
    `CHK(trg, ~v[1])
    $display("test triggered level done");
    results();
  end
endmodule // tb_top
`default_nettype wire

// [tb/tlg_load_model.sv]
// Far side model: level select observer and external trigger pin.
// Assumes the bench pulses fire_i for one clock per trigger.
`timescale 1ns/1ps
`default_nettype none
module tlg_load_model (
  // Clock
  input  wire logic        clock_i,
  // Level side
  input  wire logic        level_select_n_i,
  input  wire logic        fire_i,
  output logic             external_trigger_o,
  output logic      [31:0] edges_o,
  output logic      [31:0] gap_o
);
  logic [31:0] cnt_q  = 32'h0;
  logic        sel_q  = 1'b1;
  logic [2:0]  hold_q = 3'h0;
  logic [31:0] edges_q = 32'h0;
  logic [31:0] gap_q  = 32'h0;
  assign edges_o = edges_q;
  assign gap_o = gap_q;
  // Pin idles low; pulse held long enough for a two-flop sync
  assign external_trigger_o = (hold_q != 3'h0);
  //////////////////////////////////////////////////////////////////////////
  // active-low select picks the DAC
  always @(posedge clock_i) begin
    sel_q <= level_select_n_i;
    hold_q <= fire_i ? 3'h4 : hold_q - {2'h0, (hold_q != 3'h0)};
    if (level_select_n_i != sel_q) begin
      edges_q <= edges_q + 32'h1;
      gap_q <= cnt_q;
      cnt_q <= 32'h1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule // tlg_load_model
`default_nettype wire

// [tb/tlg_top_assertions.sv]
// Port checker for the transient level generator.
// Assumes the bus and reset contract of tlg_top.
`timescale 1ns/1ps
`default_nettype none
module tlg_top_assertions (
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        level_select_n_o,
  input wire logic        transient_enable_o,
  input wire logic        level_change_line_o,
  input wire logic        run_start_line_o,
  input wire logic [15:0] immediate_level_o,
  input wire logic [15:0] triggered_level_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic acc;
  assign acc = psel_i && penable_i && pready_o && pwrite_i;
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_cmd;
    acc && paddr_i == tlg_pkg::ADDR_CMD;
  endsequence
  sequence s_lev;
    acc && paddr_i == tlg_pkg::ADDR_LEVEL;
  endsequence
  property p_ready_next;
    s_setup |=> pready_o;
  endproperty
  property p_ready_once;
    pready_o |=> !pready_o;
  endproperty
  property p_err_zero;
    pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
  endproperty
  property p_on;
    s_cmd ##0 (pwdata_i[0] && !pwdata_i[1]) |=> transient_enable_o;
  endproperty
  property p_off;
    s_cmd ##0 pwdata_i[1] |=> !transient_enable_o;
  endproperty
  property p_hold_off;
    !transient_enable_o [*2] |-> $stable(level_select_n_o);
  endproperty
  property p_run_cause;
    $changed(run_start_line_o) |-> $past(acc && pwdata_i[3]);
  endproperty
  property p_lev_cause;
    $changed(level_change_line_o)
      |-> $past(acc && paddr_i == tlg_pkg::ADDR_LEVEL);
  endproperty
  property p_lev_wr;
    s_lev |=> immediate_level_o == $past(pwdata_i[15:0])
      && triggered_level_o == $past(pwdata_i[31:16]);
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  a_ready_once: assert property (p_ready_once)
    else $error("ready too long");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read not zero");
  a_on: assert property (p_on)
    else $error("enable not set");
  a_off: assert property (p_off)
    else $error("enable not cleared");
  a_hold_off: assert property (p_hold_off)
    else $error("select moved while disabled");
  a_run_cause: assert property (p_run_cause)
    else $error("run line moved without arm");
  a_lev_cause: assert property (p_lev_cause)
    else $error("level line moved without write");
  a_lev_wr: assert property (p_lev_wr)
    else $error("level values not taken");
endmodule // tlg_top_assertions
bind tlg_top tlg_top_assertions u_chk (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .level_select_n_o(level_select_n_o),
  .transient_enable_o(transient_enable_o),
  .level_change_line_o(level_change_line_o),
  .run_start_line_o(run_start_line_o),
  .immediate_level_o(immediate_level_o),
  .triggered_level_o(triggered_level_o));
`default_nettype wire
